// ==== rtl/btod_core.sv ====
// Byte transfer and exchange execution unit with Wishbone register access
// Summary of operation
// - The 3-bit register code selects X, A, C, B, E, D, L, H for codes 0 to 7.
// - The 2-bit pair code selects word_accum, BC, pointer_pair_two, index_pair_hi_lo for codes 0 to 3.
// - Short direct addresses lie in FE20h..FF1Fh and their word form must be even.
// - Special register operands, byte or word, never reach FFD0h..FFDFh.
// - The 11-bit call operand forms a target in 0800h..0FFFh.
// - The 5-bit table operand forms an even address in 0040h..007Fh.
// - Absolute addresses span the full 64K space and must be even for word transfers.
// - The 3-bit bit operand picks one of eight bits of the register named by the 3-bit register code, or of the status byte for a flag action.
// - Byte immediates are one byte wide and word immediates two bytes wide.
// - Register A is the byte accumulator and one side of every byte move and exchange except those with an immediate operand.
// - The word_accum pair is the word accumulator.
// - Each 16-bit pair is reachable as two separate 8-bit halves.
// - A branch offset is a signed byte added to the program counter.
// - A flag can be kept, cleared, set, set from the result or restored from a saved copy.
module btod_core
    import btod_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_lock_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_ack_i
);
    typedef enum logic [1:0] {S_IDLE, S_RD, S_WR} btod_state_e;

    btod_state_e state_q;
    logic [7:0] gpr_q [8];
    logic [7:0] psw_q, psw_sv_q, lo_q, rd_q;
    logic [15:0] pc_q, cmd_q, ea_q;
    logic [23:0] opnd_q;
    logic go_q, hi_q, bit_q, ack_q;
    logic err_a_q, err_r_q, err_op_q;
    logic [31:0] dat_q;
    logic req_q, we_q, lock_q;
    logic [7:0] wdata_q;

    logic wb_hit, wb_wr, busy, pc_wr, st_wr;
    logic [4:0] op;
    logic [2:0] rsel, mode, bsel;
    logic [1:0] rps;
    logic [7:0] immb, acc;
    logic [15:0] immw, pair, ea, tbl, addr;
    logic is_rd, is_wr, wd, err_al, err_rg, err_uo, err_any;

    function automatic logic [15:0] eff_addr(input logic [2:0] m, input logic [15:0] w,
                                             input logic [15:0] de, input logic [15:0] hl,
                                             input logic [7:0] b, input logic [7:0] c);
        case (m)
            M_SADDR: eff_addr = SADDR_BASE + {8'h00, w[7:0]};
            M_SFR: eff_addr = SFR_BASE + {8'h00, w[7:0]};
            M_ABS: eff_addr = w;
            M_DE: eff_addr = de;
            M_HL: eff_addr = hl;
            M_HLD: eff_addr = hl + {8'h00, w[7:0]};
            M_HLB: eff_addr = hl + {8'h00, b};
            default: eff_addr = hl + {8'h00, c};
        endcase
    endfunction

    function automatic logic flag_act(input logic [2:0] act, input logic cur,
                                      input logic res, input logic saved);
        case (act)
            FA_CLR: flag_act = 1'b0;
            FA_SET: flag_act = 1'b1;
            FA_RES: flag_act = res;
            FA_RESTORE: flag_act = saved;
            default: flag_act = cur;
        endcase
    endfunction

    assign op = cmd_q[CMD_OP_LSB +: 5];
    assign rsel = cmd_q[CMD_R_LSB +: 3];
    assign rps = cmd_q[CMD_RP_LSB +: 2];
    assign mode = cmd_q[CMD_MODE_LSB +: 3];
    assign bsel = cmd_q[CMD_BIT_LSB +: 3];
    assign immb = opnd_q[OPND_BYTE_LSB +: 8];
    assign immw = opnd_q[15:0];
    assign acc = gpr_q[R_A];
    assign pair = {gpr_q[{rps, 1'b1}], gpr_q[{rps, 1'b0}]};
    assign ea = eff_addr(mode, immw, {gpr_q[5], gpr_q[4]}, {gpr_q[7], gpr_q[6]},
                         gpr_q[3], gpr_q[2]);
    assign tbl = TBL_BASE + {10'h000, immw[4:0], 1'b0};
    assign addr = (op == OP_TBL5) ? tbl : ea;
    assign is_rd = (op == OP_MOV_AM) | (op == OP_XCH_AM) | (op == OP_MOVW_AM) | (op == OP_TBL5);
    assign is_wr = (op == OP_MOV_MA) | (op == OP_MOV_MI) | (op == OP_MOVW_MA);
    assign wd = (op == OP_MOVW_AM) | (op == OP_MOVW_MA) | (op == OP_TBL5);
    // Word operands in the direct windows and absolute space must be even
    assign err_al = ((op == OP_MOVW_AM) | (op == OP_MOVW_MA)) & ea[0]
                    & ((mode == M_SADDR) | (mode == M_SFR) | (mode == M_ABS));
    assign err_rg = (is_rd | is_wr) & (op != OP_TBL5) & (mode == M_SFR)
                    & (ea >= HOLE_LO) & (ea <= HOLE_HI);
    assign err_uo = op > OP_FLAG;
    assign err_any = err_al | err_rg | err_uo;

    assign busy = go_q | (state_q != S_IDLE);
    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wb_wr = wb_hit & wb_we_i;
    assign pc_wr = wb_wr & (wb_adr_i == OFS_PC) & (&wb_sel_i[1:0]);
    assign st_wr = wb_wr & (wb_adr_i == OFS_STAT) & wb_sel_i[0];

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign mem_req_o = req_q;
    assign mem_we_o = we_q;
    assign mem_lock_o = lock_q;
    assign mem_addr_o = ea_q;
    assign mem_wdata_o = wdata_q;

    // Bus slave: ack one cycle after the request, unmapped reads return zero
    always_comb begin
        case (wb_adr_i)
            OFS_CMD: rd_q = 8'h00;
            default: rd_q = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            cmd_q <= 16'h0000;
            opnd_q <= 24'h00_0000;
            go_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= wb_hit;
            go_q <= 1'b0;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    OFS_CMD: dat_q <= {16'h0000, cmd_q};
                    OFS_OPND: dat_q <= {8'h00, opnd_q};
                    OFS_STAT: dat_q <= {27'h000_0000, err_op_q, bit_q, err_r_q, err_a_q, busy};
                    OFS_REGLO: dat_q <= {gpr_q[3], gpr_q[2], gpr_q[1], gpr_q[0]};
                    OFS_REGHI: dat_q <= {gpr_q[7], gpr_q[6], gpr_q[5], gpr_q[4]};
                    OFS_PC: dat_q <= {16'h0000, pc_q};
                    OFS_PSW: dat_q <= {16'h0000, psw_sv_q, psw_q};
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
            // A command written while busy is dropped
            if (wb_wr && wb_adr_i == OFS_CMD && (&wb_sel_i[1:0]) && !busy) begin
                cmd_q <= wb_dat_i[15:0];
                go_q <= 1'b1;
            end
            if (wb_wr && wb_adr_i == OFS_OPND && !busy) begin
                for (int i = 0; i < 3; i++) begin
                    if (wb_sel_i[i]) begin
                        opnd_q[8*i +: 8] <= wb_dat_i[8*i +: 8];
                    end
                end
            end
        end
    end

    // Execution: registers, flags, program counter and the memory port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            for (int i = 0; i < 8; i++) begin
                gpr_q[i] <= GPR_RST;
            end
            psw_q <= PSW_RST;
            psw_sv_q <= PSW_RST;
            pc_q <= PC_RST;
            lo_q <= 8'h00;
            hi_q <= 1'b0;
            bit_q <= 1'b0;
            err_a_q <= 1'b0;
            err_r_q <= 1'b0;
            err_op_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            lock_q <= 1'b0;
            ea_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else if (ce_i) begin
            // Clears come first so that a same-cycle error still sets
            if (st_wr && wb_dat_i[ST_ERR_ALIGN]) begin
                err_a_q <= 1'b0;
            end
            if (st_wr && wb_dat_i[ST_ERR_RANGE]) begin
                err_r_q <= 1'b0;
            end
            if (st_wr && wb_dat_i[ST_ERR_OP]) begin
                err_op_q <= 1'b0;
            end
            if (pc_wr) begin
                pc_q <= wb_dat_i[15:0];
            end
            case (state_q)
                S_IDLE: begin
                    if (go_q && err_any) begin
                        // Only the raised flags are written, so a clear of another flag in this cycle survives
                        if (err_al) begin
                            err_a_q <= 1'b1;
                        end
                        if (err_rg) begin
                            err_r_q <= 1'b1;
                        end
                        if (err_uo) begin
                            err_op_q <= 1'b1;
                        end
                    end else if (go_q) begin
                        case (op)
                            OP_MOV_RI: gpr_q[rsel] <= immb;
                            OP_MOV_AR: gpr_q[R_A] <= gpr_q[rsel];
                            OP_MOV_RA: gpr_q[rsel] <= acc;
                            OP_PSW_I: psw_q <= immb;
                            OP_PSW_A: psw_q <= acc;
                            OP_A_PSW: gpr_q[R_A] <= psw_q;
                            OP_XCH_AR: begin
                                gpr_q[R_A] <= gpr_q[rsel];
                                gpr_q[rsel] <= acc;
                            end
                            OP_MOVW_PI: begin
                                gpr_q[{rps, 1'b1}] <= immw[15:8];
                                gpr_q[{rps, 1'b0}] <= immw[7:0];
                            end
                            OP_MOVW_AP: begin
                                gpr_q[R_A] <= pair[15:8];
                                gpr_q[R_X] <= pair[7:0];
                            end
                            OP_MOVW_PA: begin
                                gpr_q[{rps, 1'b1}] <= acc;
                                gpr_q[{rps, 1'b0}] <= gpr_q[R_X];
                            end
                            OP_XCHW: begin
                                gpr_q[{rps, 1'b1}] <= acc;
                                gpr_q[{rps, 1'b0}] <= gpr_q[R_X];
                                gpr_q[R_A] <= pair[15:8];
                                gpr_q[R_X] <= pair[7:0];
                            end
                            OP_BR: pc_q <= pc_q + {{8{immw[7]}}, immw[7:0]};
                            OP_CALL11: pc_q <= CALL_BASE | {5'h00, immw[10:0]};
                            OP_BIT: bit_q <= gpr_q[rsel][bsel];
                            OP_PSW_SAVE: psw_sv_q <= psw_q;
                            OP_FLAG: psw_q[bsel] <= flag_act(rsel, psw_q[bsel], ~|acc,
                                                             psw_sv_q[bsel]);
                            default: ;
                        endcase
                        if (is_rd || is_wr) begin
                            ea_q <= addr;
                            req_q <= 1'b1;
                            we_q <= is_wr;
                            lock_q <= (op == OP_XCH_AM);
                            hi_q <= 1'b0;
                            wdata_q <= (op == OP_MOV_MI) ? immb :
                                       (op == OP_MOVW_MA) ? gpr_q[R_X] : acc;
                            state_q <= is_wr ? S_WR : S_RD;
                        end
                    end
                end
                S_RD: begin
                    if (mem_ack_i && wd && !hi_q) begin
                        lo_q <= mem_rdata_i;
                        hi_q <= 1'b1;
                        ea_q <= ea_q + 16'h0001;
                    end else if (mem_ack_i) begin
                        case (op)
                            OP_MOVW_AM: begin
                                gpr_q[R_A] <= mem_rdata_i;
                                gpr_q[R_X] <= lo_q;
                            end
                            OP_TBL5: pc_q <= {mem_rdata_i, lo_q};
                            default: gpr_q[R_A] <= mem_rdata_i;
                        endcase
                        // The exchange keeps the lock into the write beat
                        if (op == OP_XCH_AM) begin
                            we_q <= 1'b1;
                            wdata_q <= acc;
                            state_q <= S_WR;
                        end else begin
                            req_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_WR: begin
                    if (mem_ack_i && wd && !hi_q) begin
                        hi_q <= 1'b1;
                        ea_q <= ea_q + 16'h0001;
                        wdata_q <= acc;
                    end else if (mem_ack_i) begin
                        req_q <= 1'b0;
                        we_q <= 1'b0;
                        lock_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    logic fire;
    assign fire = go_q & ce_i & (state_q == S_IDLE) & ~err_any;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_reg_code_map: assert property (
        fire && op == OP_MOV_AR && rsel == 3'h7 |=> gpr_q[R_A] == $past(gpr_q[7]))
        else $error("register code 7 did not select H");
    a_pair_code_map: assert property (
        fire && op == OP_MOVW_AP && rps == 2'h2 |=> {gpr_q[R_A], gpr_q[R_X]} == $past({gpr_q[5], gpr_q[4]}))
        else $error("pair code 2 did not select D and E");
    a_saddr_window: assert property (
        req_q && op != OP_TBL5 && mode == M_SADDR |-> ea_q >= SADDR_BASE && ea_q <= SADDR_END)
        else $error("short direct access left its window");
    a_sfr_hole_kept: assert property (
        req_q && op != OP_TBL5 && mode == M_SFR |-> !(ea_q >= HOLE_LO && ea_q <= HOLE_HI))
        else $error("special register access reached the hole");
    a_call_range: assert property (
        fire && op == OP_CALL11 |=> pc_q >= CALL_BASE && pc_q <= CALL_END)
        else $error("call target out of range");
    a_table_even: assert property (
        req_q && op == OP_TBL5 && !hi_q |-> !ea_q[0] && ea_q >= TBL_BASE && ea_q <= TBL_END)
        else $error("table address odd or out of range");
    a_word_even: assert property (
        req_q && op == OP_MOVW_MA && !hi_q && mode == M_ABS |-> !ea_q[0])
        else $error("odd absolute word transfer issued");
    a_psw_load: assert property (
        fire && op == OP_PSW_I |=> psw_q == $past(immb))
        else $error("status byte not loaded from data");
    a_xch_noflags: assert property (
        fire && op == OP_XCH_AM |=> (psw_q == $past(psw_q) && lock_q) [*2])
        else $error("exchange changed flags or lost lock");
    a_branch_add: assert property (
        fire && op == OP_BR && !pc_wr |=> pc_q == $past(pc_q) + {{8{$past(immw[7])}}, $past(immw[7:0])})
        else $error("branch target wrong");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");

    c_xch_mem: cover property (fire && op == OP_XCH_AM ##[2:40] state_q == S_IDLE);
    c_word_read: cover property (fire && op == OP_MOVW_AM ##[2:40] state_q == S_IDLE);
    c_range_err: cover property (go_q && err_rg);
    c_table: cover property (fire && op == OP_TBL5 ##[2:40] state_q == S_IDLE);
endmodule

// ==== rtl/btod_pkg.sv ====
// Constants shared by the byte transfer operand decode block
package btod_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_OPND = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_REGLO = 8'h0C;
    localparam logic [7:0] OFS_REGHI = 8'h10;
    localparam logic [7:0] OFS_PC = 8'h14;
    localparam logic [7:0] OFS_PSW = 8'h18;
    // Command field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_R_LSB = 5;
    localparam int CMD_RP_LSB = 8;
    localparam int CMD_MODE_LSB = 10;
    localparam int CMD_BIT_LSB = 13;
    // Operand field positions
    localparam int OPND_BYTE_LSB = 16;
    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_ERR_ALIGN = 1;
    localparam int ST_ERR_RANGE = 2;
    localparam int ST_BIT = 3;
    localparam int ST_ERR_OP = 4;
    // Status flag positions
    localparam int PSW_CY = 0;
    localparam int PSW_AC = 4;
    localparam int PSW_Z = 6;
    // Reset values
    localparam logic [7:0] PSW_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] GPR_RST = 8'h00;
    // General register codes
    localparam logic [2:0] R_X = 3'h0;
    localparam logic [2:0] R_A = 3'h1;
    // Address windows
    localparam logic [15:0] SADDR_BASE = 16'hFE20;
    localparam logic [15:0] SADDR_END = 16'hFF1F;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam logic [15:0] HOLE_LO = 16'hFFD0;
    localparam logic [15:0] HOLE_HI = 16'hFFDF;
    localparam logic [15:0] CALL_BASE = 16'h0800;
    localparam logic [15:0] CALL_END = 16'h0FFF;
    localparam logic [15:0] TBL_BASE = 16'h0040;
    localparam logic [15:0] TBL_END = 16'h007F;
    // Addressing modes
    localparam logic [2:0] M_SADDR = 3'h0;
    localparam logic [2:0] M_SFR = 3'h1;
    localparam logic [2:0] M_ABS = 3'h2;
    localparam logic [2:0] M_DE = 3'h3;
    localparam logic [2:0] M_HL = 3'h4;
    localparam logic [2:0] M_HLD = 3'h5;
    localparam logic [2:0] M_HLB = 3'h6;
    localparam logic [2:0] M_HLC = 3'h7;
    // Flag actions
    localparam logic [2:0] FA_KEEP = 3'h0;
    localparam logic [2:0] FA_CLR = 3'h1;
    localparam logic [2:0] FA_SET = 3'h2;
    localparam logic [2:0] FA_RES = 3'h3;
    localparam logic [2:0] FA_RESTORE = 3'h4;
    // Operation codes
    localparam logic [4:0] OP_MOV_RI = 5'h00;
    localparam logic [4:0] OP_MOV_AR = 5'h01;
    localparam logic [4:0] OP_MOV_RA = 5'h02;
    localparam logic [4:0] OP_MOV_AM = 5'h03;
    localparam logic [4:0] OP_MOV_MA = 5'h04;
    localparam logic [4:0] OP_MOV_MI = 5'h05;
    localparam logic [4:0] OP_PSW_I = 5'h06;
    localparam logic [4:0] OP_PSW_A = 5'h07;
    localparam logic [4:0] OP_A_PSW = 5'h08;
    localparam logic [4:0] OP_XCH_AR = 5'h09;
    localparam logic [4:0] OP_XCH_AM = 5'h0A;
    localparam logic [4:0] OP_MOVW_PI = 5'h0B;
    localparam logic [4:0] OP_MOVW_AP = 5'h0C;
    localparam logic [4:0] OP_MOVW_PA = 5'h0D;
    localparam logic [4:0] OP_XCHW = 5'h0E;
    localparam logic [4:0] OP_MOVW_AM = 5'h0F;
    localparam logic [4:0] OP_MOVW_MA = 5'h10;
    localparam logic [4:0] OP_BR = 5'h11;
    localparam logic [4:0] OP_CALL11 = 5'h12;
    localparam logic [4:0] OP_TBL5 = 5'h13;
    localparam logic [4:0] OP_BIT = 5'h14;
    localparam logic [4:0] OP_PSW_SAVE = 5'h15;
    localparam logic [4:0] OP_FLAG = 5'h16;
endpackage

// ==== verification/btod_mem_model.sv ====
// Byte-wide data memory model on the far side of the core's memory port
module btod_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] dly_i,
    output logic [7:0] rdata_o,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic [1:0] cnt_q;
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 37 + (i >> 8));
    // Between answers the data lines flip, so a stale byte is never mistaken for a read
    assign rdata_o = ack_o ? mem[addr_i] : ~last_q;
    always @(posedge clk_i) begin
        if (ack_o && req_i && we_i) mem[addr_i] <= wdata_i;
        if (ack_o) last_q <= rdata_o;
        if (rst_i || ack_o || !req_i) begin
            ack_o <= 1'b0;
            cnt_q <= 2'h0;
        end else if (cnt_q == dly_i) ack_o <= 1'b1;
        else cnt_q <= cnt_q + 2'h1;
    end
endmodule

// ==== verification/byte_transfer_operand_decode_tb_top.sv ====
// Self-checking bench for the byte transfer operand decode core
module byte_transfer_operand_decode_tb_top
    import btod_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, ce_i, cyc, stb, we, wb_ack, mreq, mwe, mack;
    logic [7:0] adr, mrd, mwd;
    logic [3:0] sel;
    logic [31:0] dat, rdat;
    logic [15:0] maddr;
    logic [1:0] dly;
    logic [7:0] g [8];
    logic [7:0] cpu_status_byte, sav;
    int miscompares, total_checks;
    btod_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .mem_req_o(mreq),
        .mem_we_o(mwe), .mem_lock_o(), .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrd), .mem_ack_i(mack));
    btod_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
        .wdata_i(mwd), .dly_i(dly), .rdata_o(mrd), .ack_o(mack));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20) miscompares++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic run(input logic [4:0] op, input logic [2:0] r, input logic [1:0] rp, input logic [2:0] m,
        input logic [2:0] b, input logic [23:0] o);
        logic [31:0] q;
        int n;
        n = 0;
        dly <= 2'($urandom);
        wr(OFS_OPND, {8'h00, o});
        wr(OFS_CMD, {16'h0000, b, m, rp, r, op});
        do begin
            rd(OFS_STAT, q);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 50);
        if (n == 50) miscompares++;
    endtask
    task automatic regs();
        logic [31:0] q;
        rd(OFS_REGLO, q);
        chk(q, {g[3], g[2], g[1], g[0]});
        rd(OFS_REGHI, q);
        chk(q, {g[7], g[6], g[5], g[4]});
    endtask
    function automatic logic [15:0] ea(input logic [2:0] m, input logic [15:0] o);
        logic [15:0] hl;
        hl = {g[7], g[6]};
        case (m)
            M_SADDR: ea = SADDR_BASE + {8'h00, o[7:0]};
            M_SFR: ea = SFR_BASE + {8'h00, o[7:0]};
            M_ABS: ea = o;
            M_DE: ea = {g[5], g[4]};
            M_HL: ea = hl;
            M_HLD: ea = hl + {8'h00, o[7:0]};
            M_HLB: ea = hl + {8'h00, g[3]};
            default: ea = hl + {8'h00, g[2]};
        endcase
    endfunction
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Generous bound: the whole sequence needs under a thousand of the 20000 cycles allowed
    initial begin
        #2000000;
        miscompares++;
        wrap_up();
    end
    initial begin
        logic [31:0] q;
        logic [15:0] o, a, pc;
        logic [7:0] v, t;
        logic [2:0] r;
        {rst_i, ce_i, sel} = {1'b1, 1'b1, 4'hF};
        {cyc, stb, we, adr, dat, dly, miscompares, total_checks} = '0;
        void'($urandom(32'hE84BA348));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) g[i] = GPR_RST;
        regs();
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            run(OP_MOV_RI, 3'(i), 2'h0, 3'h0, 3'h0, {v, 16'h0000});
            g[i] = v;
        end
        regs();
        for (int i = 0; i < 4; i++) begin
            o = 16'($urandom);
            run(OP_MOVW_PI, 3'h0, 2'(i), 3'h0, 3'h0, {8'h00, o});
            {g[2 * i + 1], g[2 * i]} = o;
        end
        regs();
        for (int m = 0; m < 8; m++) begin
            o = 16'($urandom);
            if (m == 0) o[7:0] = 8'hFF;
            if (m == 1 && o[7:4] == 4'hD) o[7:4] = 4'h0;
            a = ea(3'(m), o);
            run(OP_MOV_AM, 3'h0, 2'h0, 3'(m), 3'h0, {8'h00, o});
            g[1] = i_mem.mem[a];
            regs();
        end
        o = 16'($urandom) & 16'hFFFE;
        run(OP_MOVW_AM, 3'h0, 2'h0, M_ABS, 3'h0, {8'h00, o});
        {g[1], g[0]} = {i_mem.mem[o + 16'h1], i_mem.mem[o]};
        regs();
        run(OP_MOV_AM, 3'h0, 2'h0, M_SFR, 3'h0, {16'h00D0 | 16'($urandom % 16)});
        rd(OFS_STAT, q);
        chk(q, 32'h0000_0004);
        run(OP_MOVW_AM, 3'h0, 2'h0, M_SADDR, 3'h0, {16'h0001 | 16'($urandom)});
        rd(OFS_STAT, q);
        chk(q, 32'h0000_0006);
        regs();
        wr(OFS_STAT, 32'h0000_001F);
        rd(OFS_STAT, q);
        chk(q, 32'h0);
        v = 8'($urandom);
        run(OP_PSW_I, 3'h0, 2'h0, 3'h0, 3'h0, {v, 16'h0000});
        rd(OFS_PSW, q);
        chk(q, {24'h0, v});
        run(OP_PSW_A, 3'h0, 2'h0, 3'h0, 3'h0, 24'h0);
        rd(OFS_PSW, q);
        chk(q, {24'h0, g[1]});
        sav = g[1];
        run(OP_PSW_SAVE, 3'h0, 2'h0, 3'h0, 3'h0, 24'h0);
        run(OP_PSW_I, 3'h0, 2'h0, 3'h0, 3'h0, {~sav, 16'h0000});
        run(OP_MOV_RI, R_A, 2'h0, 3'h0, 3'h0, 24'h0);
        {cpu_status_byte, g[1]} = {~sav, 8'h00};
        for (int act = 0; act < 5; act++) begin
            r = 3'($urandom);
            run(OP_FLAG, 3'(act), 2'h0, 3'h0, r, 24'h0);
            if (act == 1) cpu_status_byte[r] = 1'b0;
            else if (act == 2) cpu_status_byte[r] = 1'b1;
            else if (act == 3) cpu_status_byte[r] = 1'b1;
            else if (act == 4) cpu_status_byte[r] = sav[r];
            rd(OFS_PSW, q);
            chk(q, {16'h0, sav, cpu_status_byte});
        end
        run(OP_MOV_AR, 3'h7, 2'h0, 3'h0, 3'h0, 24'h0);
        g[1] = g[7];
        r = 3'($urandom % 6 + 2);
        run(OP_MOV_RA, r, 2'h0, 3'h0, 3'h0, 24'h0);
        g[r] = g[1];
        run(OP_MOVW_AP, 3'h0, 2'h2, 3'h0, 3'h0, 24'h0);
        {g[1], g[0]} = {g[5], g[4]};
        run(OP_XCHW, 3'h0, 2'h3, 3'h0, 3'h0, 24'h0);
        {g[1], g[0], g[7], g[6]} = {g[7], g[6], g[1], g[0]};
        regs();
        o = 16'($urandom) & 16'hFFFE;
        run(OP_MOVW_MA, 3'h0, 2'h0, M_ABS, 3'h0, {8'h00, o});
        chk({16'h0, i_mem.mem[o + 16'h1], i_mem.mem[o]}, {16'h0, g[1], g[0]});
        o = 16'($urandom);
        a = ea(M_SADDR, o);
        {t, v} = {i_mem.mem[a], g[1]};
        run(OP_XCH_AM, 3'h0, 2'h0, M_SADDR, 3'h0, {8'h00, o});
        g[1] = t;
        regs();
        chk({24'h0, i_mem.mem[a]}, {24'h0, v});
        r = 3'($urandom % 6 + 2);
        run(OP_XCH_AR, r, 2'h0, 3'h0, 3'h0, 24'h0);
        {g[1], g[r]} = {g[r], g[1]};
        regs();
        rd(OFS_PSW, q);
        chk(q, {16'h0, sav, cpu_status_byte});
        for (int i = 0; i < 3; i++) begin
            pc = 16'($urandom);
            o = (i == 0) ? 16'h0080 : (i == 1) ? 16'h007F : 16'($urandom);
            wr(OFS_PC, {16'h0, pc});
            run(OP_BR, 3'h0, 2'h0, 3'h0, 3'h0, {8'h00, o});
            rd(OFS_PC, q);
            chk(q, {16'h0, pc + {{8{o[7]}}, o[7:0]}});
        end
        o = 16'($urandom);
        run(OP_CALL11, 3'h0, 2'h0, 3'h0, 3'h0, {8'h00, o});
        rd(OFS_PC, q);
        chk(q, {16'h0, CALL_BASE | {5'h00, o[10:0]}});
        o = 16'($urandom);
        a = TBL_BASE + {10'h000, o[4:0], 1'b0};
        run(OP_TBL5, 3'h0, 2'h0, 3'h0, 3'h0, {8'h00, o});
        rd(OFS_PC, q);
        chk(q, {16'h0, i_mem.mem[a + 16'h1], i_mem.mem[a]});
        for (int b = 0; b < 8; b++) begin
            r = 3'($urandom);
            run(OP_BIT, r, 2'h0, 3'h0, 3'(b), 24'h0);
            rd(OFS_STAT, q);
            chk(32'(q[ST_BIT]), 32'(g[r][b]));
        end
        rd(8'hFC, q);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule
